// ---- touch_pkg.sv ----
// Constants, register map and state codes for the touch channel event logic.
// Assumes a single 100 MHz clock domain shared by every design file.
package touch_pkg;
   localparam int          NUM_CH           = 8;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          SAMPLE_PERIOD_NS = 1000;
   localparam int          SAMPLE_DIV       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [6:0]  SAMPLE_DIV_M1    = 7'(SAMPLE_DIV - 1);
   localparam int          I2C_MAX_KHZ      = 400;
   localparam logic [4:0]  SLAVE_ADDR_HI    = 5'h11;
   localparam logic [7:0]  REG_TOUCH_STATUS = 8'h00;
   localparam logic [7:0]  REG_CHAN_DISABLE = 8'h01;
   localparam logic [7:0]  REG_IRQ_CONFIG   = 8'h02;
   localparam logic [7:0]  REG_EVENT_FLAGS  = 8'h03;
   localparam logic [7:0]  CHAN_DISABLE_RST = 8'h00;
   localparam logic [2:0]  IRQ_CONFIG_RST   = 3'h3;
   localparam int          IRQ_TOUCH_BIT    = 0;
   localparam int          IRQ_RELEASE_BIT  = 1;
   localparam int          IRQ_W1C_BIT      = 2;
   localparam logic [7:0]  TOUCH_ON_DELTA   = 8'h20;
   localparam logic [7:0]  TOUCH_OFF_DELTA  = 8'h10;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_REG  = 3'b010,
      ST_WR   = 3'b011,
      ST_ACK  = 3'b100,
      ST_RD   = 3'b101,
      ST_RACK = 3'b110
   } i2c_state_e;
endpackage

// ---- touch_tracker.sv ----
// One sense channel: baseline tracking and touch decision with hysteresis.
// Assumes a sample value and a one-cycle sample tick synchronous to sys_clk_in.
`timescale 1ns/10ps
`default_nettype none
module touch_tracker
   import touch_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       active_in,
   input  wire logic       tick_in,
   input  wire logic [7:0] sample_in,
   output logic            pressed_out
);
   logic [7:0] baseline_q, baseline_d;
   logic       init_q, init_d;
   logic       pressed_q, pressed_d;

   function automatic logic [7:0] add_sat(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[8] ? 8'hff : s[7:0];
   endfunction

   always_comb begin
      baseline_d = baseline_q;
      init_d     = init_q;
      pressed_d  = pressed_q;
      if (!active_in) begin
         init_d    = 1'b0;
         pressed_d = 1'b0;
      end else if (tick_in) begin
         if (!init_q) begin
            baseline_d = sample_in;
            init_d     = 1'b1;
         end else begin
            if (!pressed_q && sample_in >= add_sat(baseline_q, TOUCH_ON_DELTA)) begin
               pressed_d = 1'b1;
            end else if (pressed_q && sample_in <= add_sat(baseline_q, TOUCH_OFF_DELTA)) begin
               pressed_d = 1'b0;
            end
            if (!pressed_q && sample_in > baseline_q) begin
               baseline_d = baseline_q + 8'h01;
            end else if (!pressed_q && sample_in < baseline_q) begin
               baseline_d = baseline_q - 8'h01;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         baseline_q <= 8'h00;
         init_q     <= 1'b0;
         pressed_q  <= 1'b0;
      end else begin
         baseline_q <= baseline_d;
         init_q     <= init_d;
         pressed_q  <= pressed_d;
      end
   end

   assign pressed_out = pressed_q;

   chk_baseline_drift: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (active_in && tick_in && init_q && !pressed_q && sample_in > baseline_q)
      |=> (baseline_q == $past(baseline_q) + 8'h01))
      else $error("Baseline did not follow a rising idle sample.");
   chk_touch_threshold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (active_in && tick_in && init_q && !pressed_q && baseline_q < 8'hc0
       && sample_in >= baseline_q + TOUCH_ON_DELTA) |=> pressed_q)
      else $error("Touch above the on threshold was not detected.");
endmodule // touch_tracker
`default_nettype wire

// ---- touch_channel_event_logic.sv ----
// Eight-channel touch output, event and register logic with an I2C slave port.
// Assumes SCL, SDA, strap and sense samples are synchronous to sys_clk_in.
//
// Contract
// - Eight independent sense channels exist, each with a sense input and a touch output.
// - A channel's touch output is pulled low while that channel is detected as pressed.
// - The active-low interrupt line asserts when a touch or release event occurs.
// - The interrupt configuration register selects which events set and how they clear.
// - Holding the shutdown input low stops sensing.
// - Channels are disabled by the register at 01h, and the host disables unused ones; the bench writes 80h, leaving unused channels 5 and 6 enabled.
// - Calibration tracks the environment and moves the on and off thresholds.
// - The device is an I2C slave for bus clocks up to 400 kHz, which the master keeps to.
// - The slave address is 10001 followed by the two strap bits.
`timescale 1ns/10ps
`default_nettype none
module touch_channel_event_logic
   import touch_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 shutdown_n_in,
   input  wire logic [NUM_CH-1:0][7:0] sense_inputs_in,
   input  wire logic [1:0]           ad_sel_in,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe_n_out,
   output logic [NUM_CH-1:0]         touch_outputs_out,
   output logic [NUM_CH-1:0]         touch_outputs_oe_n_out,
   output logic                      irq_line_low_out
);
   i2c_state_e        state_q, state_d, next_q, next_d;
   logic [7:0]        shift_q, shift_d, ptr_q, ptr_d;
   logic [2:0]        bitcnt_q, bitcnt_d;
   logic              done_q, done_d, nack_q, nack_d, oe_n_q, oe_n_d;
   logic              scl_prev_q, sda_prev_q;
   logic              scl_rise, scl_fall, start_c, stop_c, wr_en, rd_done;
   logic [NUM_CH-1:0] chan_disable_q, chan_disable_d;
   logic [2:0]        irq_cfg_q, irq_cfg_d;
   logic [NUM_CH-1:0] flags_q, flags_d, prev_q, clr, new_ev;
   logic [NUM_CH-1:0] pressed, oe_n_out_q;
   logic              irq_q, irq_d;
   logic [6:0]        tick_cnt_q, tick_cnt_d;
   logic              tick;

   function automatic logic [7:0] reg_read(input logic [7:0] addr);
      case (addr)
         REG_TOUCH_STATUS: return pressed;
         REG_CHAN_DISABLE: return chan_disable_q;
         REG_IRQ_CONFIG:   return {5'h00, irq_cfg_q};
         REG_EVENT_FLAGS:  return flags_q;
         default:          return 8'h00;
      endcase
   endfunction

   // Sample tick divider for the channel trackers.
   always_comb begin
      tick       = (tick_cnt_q == SAMPLE_DIV_M1);
      tick_cnt_d = tick ? 7'h00 : tick_cnt_q + 7'h01;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         touch_tracker u_trk (
            .sys_clk_in  (sys_clk_in),
            .rst_n_in    (rst_n_in),
            .active_in   (shutdown_n_in & ~chan_disable_q[gi]),
            .tick_in     (tick),
            .sample_in   (sense_inputs_in[gi]),
            .pressed_out (pressed[gi])
         );
      end
   endgenerate

   // Bus edges, sampled far above the 400 kHz bus rate.
   always_comb begin
      scl_rise = scl_in & ~scl_prev_q;
      scl_fall = ~scl_in & scl_prev_q;
      start_c  = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
      stop_c   = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
   end

   always_comb begin
      state_d  = state_q;
      next_d   = next_q;
      shift_d  = shift_q;
      ptr_d    = ptr_q;
      bitcnt_d = bitcnt_q;
      done_d   = done_q;
      nack_d   = nack_q;
      oe_n_d   = oe_n_q;
      wr_en    = 1'b0;
      rd_done  = 1'b0;
      if (stop_c) begin
         state_d = ST_IDLE;
         oe_n_d  = 1'b1;
      end else if (start_c) begin
         state_d  = ST_ADDR;
         bitcnt_d = 3'h0;
         done_d   = 1'b0;
         oe_n_d   = 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: begin
               oe_n_d = 1'b1;
            end
            ST_ADDR, ST_REG, ST_WR: begin
               if (scl_rise) begin
                  shift_d  = {shift_q[6:0], sda_in};
                  bitcnt_d = bitcnt_q + 3'h1;
                  done_d   = (bitcnt_q == 3'h7);
               end else if (scl_fall && done_q) begin
                  done_d  = 1'b0;
                  oe_n_d  = 1'b0;
                  state_d = ST_ACK;
                  next_d  = ST_WR;
                  if (state_q == ST_ADDR) begin
                     next_d = shift_q[0] ? ST_RD : ST_REG;
                     if (shift_q[7:1] != {SLAVE_ADDR_HI, ad_sel_in}) begin
                        state_d = ST_IDLE;
                        oe_n_d  = 1'b1;
                     end
                  end else if (state_q == ST_REG) begin
                     ptr_d = shift_q;
                  end else begin
                     wr_en = 1'b1;
                     ptr_d = ptr_q + 8'h01;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  oe_n_d   = 1'b1;
                  bitcnt_d = 3'h0;
                  state_d  = next_q;
                  if (next_q == ST_RD) begin
                     shift_d = reg_read(ptr_q);
                     oe_n_d  = shift_d[7];
                  end
               end
            end
            ST_RD: begin
               if (scl_rise) begin
                  bitcnt_d = bitcnt_q + 3'h1;
                  done_d   = (bitcnt_q == 3'h7);
               end else if (scl_fall) begin
                  if (done_q) begin
                     done_d  = 1'b0;
                     oe_n_d  = 1'b1;
                     state_d = ST_RACK;
                     rd_done = 1'b1;
                     ptr_d   = ptr_q + 8'h01;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_n_d  = shift_d[7];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_d = sda_in;
               end else if (scl_fall) begin
                  if (nack_q) begin
                     state_d = ST_IDLE;
                  end else begin
                     shift_d  = reg_read(ptr_q);
                     oe_n_d   = shift_d[7];
                     bitcnt_d = 3'h0;
                     state_d  = ST_RD;
                  end
               end
            end
            default: begin
               state_d = ST_IDLE;
               oe_n_d  = 1'b1;
            end
         endcase
      end
   end

   // Registers, event flags and pin drive.
   always_comb begin
      chan_disable_d = chan_disable_q;
      irq_cfg_d      = irq_cfg_q;
      if (wr_en && ptr_q == REG_CHAN_DISABLE) begin
         chan_disable_d = shift_q;
      end
      if (wr_en && ptr_q == REG_IRQ_CONFIG) begin
         irq_cfg_d = shift_q[2:0];
      end
      new_ev = (pressed & ~prev_q & {NUM_CH{irq_cfg_q[IRQ_TOUCH_BIT]}})
             | (~pressed & prev_q & {NUM_CH{irq_cfg_q[IRQ_RELEASE_BIT]}});
      clr = '0;
      if (irq_cfg_q[IRQ_W1C_BIT]) begin
         if (wr_en && ptr_q == REG_EVENT_FLAGS) begin
            clr = shift_q;
         end
      end else if (rd_done && ptr_q == REG_EVENT_FLAGS) begin
         clr = '1;
      end
      flags_d = (flags_q & ~clr) | new_ev;
      if (!shutdown_n_in) begin
         flags_d = '0;
      end
      irq_d = ~(|flags_d);
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q        <= ST_IDLE;
         next_q         <= ST_IDLE;
         shift_q        <= 8'h00;
         ptr_q          <= 8'h00;
         bitcnt_q       <= 3'h0;
         done_q         <= 1'b0;
         nack_q         <= 1'b0;
         oe_n_q         <= 1'b1;
         scl_prev_q     <= 1'b1;
         sda_prev_q     <= 1'b1;
         chan_disable_q <= CHAN_DISABLE_RST;
         irq_cfg_q      <= IRQ_CONFIG_RST;
         flags_q        <= '0;
         prev_q         <= '0;
         irq_q          <= 1'b1;
         oe_n_out_q     <= '1;
         tick_cnt_q     <= 7'h00;
      end else begin
         state_q        <= state_d;
         next_q         <= next_d;
         shift_q        <= shift_d;
         ptr_q          <= ptr_d;
         bitcnt_q       <= bitcnt_d;
         done_q         <= done_d;
         nack_q         <= nack_d;
         oe_n_q         <= oe_n_d;
         scl_prev_q     <= scl_in;
         sda_prev_q     <= sda_in;
         chan_disable_q <= chan_disable_d;
         irq_cfg_q      <= irq_cfg_d;
         flags_q        <= flags_d;
         prev_q         <= pressed;
         irq_q          <= irq_d;
         oe_n_out_q     <= ~pressed;
         tick_cnt_q     <= tick_cnt_d;
      end
   end

   assign sda_out                = 1'b0;
   assign sda_oe_n_out           = oe_n_q;
   assign touch_outputs_out      = '0;
   assign touch_outputs_oe_n_out = oe_n_out_q;
   assign irq_line_low_out       = irq_q;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_press_pulls_low: assert property ($rose(pressed[0]) |=> !touch_outputs_oe_n_out[0])
      else $error("Pressed channel did not pull its output low.");
   chk_release_floats: assert property ($fell(pressed[0]) |=> touch_outputs_oe_n_out[0])
      else $error("Released channel output did not float.");
   chk_event_irq: assert property ((|new_ev) && shutdown_n_in |=> !irq_line_low_out)
      else $error("Event did not assert the interrupt line.");
   chk_masked_quiet: assert property ((!irq_cfg_q[IRQ_RELEASE_BIT]
      && (pressed & ~prev_q) == '0 && shutdown_n_in)
      |=> (flags_q & ~$past(flags_q)) == '0)
      else $error("Masked release event set a flag.");
   chk_read_clears: assert property ((rd_done && ptr_q == REG_EVENT_FLAGS
      && !irq_cfg_q[IRQ_W1C_BIT] && new_ev == '0) |=> flags_q == '0)
      else $error("Reading the event flags did not clear them.");
   chk_shutdown_idle: assert property (!shutdown_n_in [*3] |->
      (&touch_outputs_oe_n_out) && irq_line_low_out)
      else $error("Shutdown did not stop sensing.");
   chk_disabled_float: assert property (chan_disable_q[7] [*3] |-> touch_outputs_oe_n_out[7])
      else $error("Disabled channel drove its output.");
   chk_disable_write: assert property (wr_en && ptr_q == REG_CHAN_DISABLE
      |=> chan_disable_q == $past(shift_q))
      else $error("Channel disable write was lost.");
   chk_addr_ack: assert property ((state_q == ST_ADDR && scl_fall && done_q && !start_c
      && !stop_c && shift_q[7:1] == {SLAVE_ADDR_HI, ad_sel_in})
      |=> state_q == ST_ACK && !sda_oe_n_out)
      else $error("Own address was not acknowledged.");
   chk_addr_reject: assert property ((state_q == ST_ADDR && scl_fall && done_q && !start_c
      && !stop_c && shift_q[7:1] != {SLAVE_ADDR_HI, ad_sel_in})
      |=> state_q == ST_IDLE && sda_oe_n_out)
      else $error("Foreign address was acknowledged.");

   cov_touch: cover property ($rose(pressed[0]) ##[1:1000] $fell(pressed[0]));
   cov_irq: cover property ($fell(irq_line_low_out));
   cov_reg_write: cover property (wr_en && ptr_q == REG_IRQ_CONFIG);
   cov_reg_read: cover property (rd_done && ptr_q == REG_EVENT_FLAGS);
endmodule // touch_channel_event_logic
`default_nettype wire

// ---- i2c_host_model.sv ----
// Bus master model that reaches the touch block's registers over its two-wire port.
// Assumes the bench resolves the data wire with a pull-up and feeds it back as sda_in.
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
   input  wire logic sys_clk_in,
   input  wire logic sda_in,
   output var logic  scl_out,
   output var logic  sda_oe_n_out
);
   initial begin
      scl_out = 1'b1;
      sda_oe_n_out = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   // Each bit is 130 clocks low and 120 high, 2.5 us, so the bus runs at 400 kHz.
   task automatic put_bit(input logic b, output logic r);
      scl_out <= 1'b0;
      w(65);
      sda_oe_n_out <= b;
      w(65);
      scl_out <= 1'b1;
      w(119);
      r = sda_in;
      w(1);
   endtask
   task automatic start();
      scl_out <= 1'b0;
      w(65);
      sda_oe_n_out <= 1'b1;
      w(65);
      scl_out <= 1'b1;
      w(60);
      sda_oe_n_out <= 1'b0;
      w(60);
   endtask
   task automatic stop();
      scl_out <= 1'b0;
      w(65);
      sda_oe_n_out <= 1'b0;
      w(65);
      scl_out <= 1'b1;
      w(60);
      sda_oe_n_out <= 1'b1;
      w(60);
   endtask
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], b);
         q[i] = b;
      end
      put_bit(last, b);
      ack = ~b;
   endtask
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d,
                            output logic ok);
      logic [7:0] t;
      logic       a0;
      logic       a1;
      logic       a2;
      a1 = 1'b0;
      a2 = 1'b0;
      start();
      xfer({dev, 1'b0}, 1'b1, t, a0);
      if (a0) begin
         xfer(r, 1'b1, t, a1);
         xfer(d, 1'b1, t, a2);
      end
      stop();
      ok = a0 & a1 & a2;
   endtask
   // Pointer write, repeated start, then n bytes read, the last one refused.
   task automatic read_regs(input logic [6:0] dev, input logic [7:0] r, input int n,
                            output logic [3:0][7:0] q, output logic ok);
      logic [7:0] t;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       a3;
      q = '0;
      start();
      xfer({dev, 1'b0}, 1'b1, t, a0);
      xfer(r, 1'b1, t, a1);
      start();
      xfer({dev, 1'b1}, 1'b1, t, a2);
      for (int i = 0; i < n; i++) begin
         xfer(8'hff, 1'(i == n - 1), t, a3);
         q[i] = t;
      end
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule // i2c_host_model
`default_nettype wire

// ---- test_touch_channel_event_logic.sv ----
// Self-checking bench for the touch channel event logic, driven over its two-wire port.
// Assumes the host model in i2c_host_model.sv and a pull-up on the data wire.
`timescale 1ns/10ps
`default_nettype none
module test_touch_channel_event_logic;
   import touch_pkg::*;
   logic                   sys_clk_in = 1'b0;
   logic                   rst_n_in = 1'b0;
   logic                   shutdown_n_in = 1'b1;
   logic [NUM_CH-1:0][7:0] sense_inputs_in = {NUM_CH{8'h40}};
   logic [1:0]             ad_sel_in = 2'h0;
   logic                   scl;
   logic                   host_oe_n;
   logic                   sda_out;
   logic                   sda_oe_n_out;
   logic                   irq_line_low_out;
   logic [NUM_CH-1:0]      touch_outputs_out;
   logic [NUM_CH-1:0]      touch_outputs_oe_n_out;
   logic [3:0][7:0]        q;
   logic [6:0]             dev;
   logic                   ok;
   int                     n_mismatch = 0;
   int                     compares = 0;
   wire logic              sda = host_oe_n & sda_oe_n_out;

   always #5 sys_clk_in = ~sys_clk_in;

   i2c_host_model host (.sys_clk_in(sys_clk_in), .sda_in(sda), .scl_out(scl),
                        .sda_oe_n_out(host_oe_n));
   touch_channel_event_logic DUT (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .shutdown_n_in(shutdown_n_in),
      .sense_inputs_in(sense_inputs_in), .ad_sel_in(ad_sel_in), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
      .touch_outputs_out(touch_outputs_out),
      .touch_outputs_oe_n_out(touch_outputs_oe_n_out),
      .irq_line_low_out(irq_line_low_out));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      host.write_reg(dev, r, d, ok);
      check(8'(ok), 8'h01);
   endtask
   task automatic rd(input logic [7:0] r, input int n);
      host.read_regs(dev, r, n, q, ok);
      check(8'(ok), 8'h01);
   endtask
   task automatic set_sense(input int ch, input logic [7:0] v);
      @(posedge sys_clk_in);
      sense_inputs_in[ch] <= v;
   endtask
   task automatic wait_out(input int ch, input logic v);
      for (int i = 0; i < 600 && touch_outputs_oe_n_out[ch] !== v; i++)
         @(negedge sys_clk_in);
   endtask

   initial begin
      repeat (95000) @(posedge sys_clk_in);
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      dev = {SLAVE_ADDR_HI, 2'h0};
      repeat (10) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      repeat (5) @(negedge sys_clk_in);
      check(touch_outputs_oe_n_out, 8'hff);
      check(touch_outputs_out, 8'h00);
      check(8'(sda_out), 8'h00);
      check(8'(irq_line_low_out), 8'h01);
      rd(REG_CHAN_DISABLE, 3);
      check(q[0], CHAN_DISABLE_RST);
      check(q[1], 8'(IRQ_CONFIG_RST));
      check(q[2], 8'h00);
      $display("test 1 done: reset values");
      @(posedge sys_clk_in);
      ad_sel_in <= 2'h3;
      host.write_reg(dev, REG_CHAN_DISABLE, 8'hff, ok);
      check(8'(ok), 8'h00);
      dev = {SLAVE_ADDR_HI, 2'h3};
      wr(REG_CHAN_DISABLE, 8'h80);
      $display("test 2 done: address strap");
      fork
         for (int v = 8'h41; v <= 8'h70; v++) begin
            repeat (200) @(posedge sys_clk_in);
            sense_inputs_in[3] <= 8'(v);
         end
      join_none
      set_sense(0, 8'h60);
      wait_out(0, 1'b0);
      check(8'(touch_outputs_oe_n_out[0]), 8'h00);
      check(8'(irq_line_low_out), 8'h00);
      rd(REG_TOUCH_STATUS, 4);
      check(q[0], 8'h01);
      check(q[1], 8'h80);
      check(q[2], 8'h03);
      check(q[3], 8'h01);
      check(8'(irq_line_low_out), 8'h01);
      $display("test 3 done: touch event");
      set_sense(0, 8'h50);
      wait_out(0, 1'b1);
      check(8'(touch_outputs_oe_n_out[0]), 8'h01);
      check(8'(irq_line_low_out), 8'h00);
      wr(REG_IRQ_CONFIG, 8'h05);
      wr(REG_EVENT_FLAGS, 8'h01);
      check(8'(irq_line_low_out), 8'h01);
      $display("test 4 done: release event");
      set_sense(1, 8'h60);
      wait_out(1, 1'b0);
      check(8'(irq_line_low_out), 8'h00);
      rd(REG_EVENT_FLAGS, 1);
      check(q[0], 8'h02);
      check(8'(irq_line_low_out), 8'h00);
      wr(REG_EVENT_FLAGS, 8'h02);
      check(8'(irq_line_low_out), 8'h01);
      set_sense(1, 8'h40);
      wait_out(1, 1'b1);
      repeat (2) @(negedge sys_clk_in);
      check(8'(touch_outputs_oe_n_out[1]), 8'h01);
      check(8'(irq_line_low_out), 8'h01);
      check(8'(touch_outputs_oe_n_out[3]), 8'h01);
      $display("test 5 done: interrupt configuration");
      set_sense(7, 8'h70);
      repeat (300) @(negedge sys_clk_in);
      check(8'(touch_outputs_oe_n_out[7]), 8'h01);
      wr(REG_IRQ_CONFIG, 8'h06);
      set_sense(2, 8'h70);
      set_sense(4, 8'h70);
      wait_out(4, 1'b0);
      wait_out(2, 1'b0);
      check(touch_outputs_oe_n_out, 8'heb);
      check(8'(irq_line_low_out), 8'h01);
      set_sense(4, 8'h40);
      wait_out(4, 1'b1);
      check(8'(irq_line_low_out), 8'h00);
      @(posedge sys_clk_in);
      shutdown_n_in <= 1'b0;
      repeat (5) @(negedge sys_clk_in);
      check(touch_outputs_oe_n_out, 8'hff);
      check(8'(irq_line_low_out), 8'h01);
      $display("test 6 done: disable and shutdown");
      tally_and_finish();
   end
endmodule // test_touch_channel_event_logic
`default_nettype wire
